// file: common/cbc_map.vh
// Register map, field positions, reset values and pin encodings of the clock buffer control.
`ifndef CBC_MAP_VH
`define CBC_MAP_VH
`define CBC_IDX_MODE 8'h00
`define CBC_IDX_OEL 8'h01
`define CBC_IDX_OEH 8'h02
`define CBC_IDX_REVID 8'h05
`define CBC_IDX_DEVID 8'h06
`define CBC_IDX_COUNT 8'h07
`define CBC_IDX_SKEWA 8'h08
`define CBC_IDX_SKEWB 8'h09
`define CBC_MODE_WMASK 8'h0E
`define CBC_MODE_RST 8'h07
`define CBC_OEL_RST 8'hFF
`define CBC_OEH_RST 8'h0F
`define CBC_OEH_WMASK 8'h0F
`define CBC_COUNT_RST 8'h08
`define CBC_COUNT_WMASK 8'h1F
`define CBC_SKEW_WMASK 8'h07
`define CBC_PLL_LOBW 2'h0
`define CBC_PLL_BYPASS 2'h1
`define CBC_PLL_HIBW 2'h3
`define CBC_TRI_LOW 2'h0
`define CBC_TRI_MID 2'h1
`define CBC_TRI_HIGH 2'h2
`define CBC_ADDR_LOW 7'h6C
`define CBC_ADDR_MID 7'h6D
`define CBC_ADDR_HIGH 7'h6F
`define CBC_BIT_SWEN 3
`define CBC_BIT_SEL 5
`endif

// file: logic/cbc_sync.v
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module cbc_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire core_clk,
   input wire reset,
   // Data
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   always @(posedge core_clk) begin
      if (reset) begin
         meta_q <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // cbc_sync
`default_nettype wire

// file: logic/cbc_smb_slave.v
// SMBus byte-level slave: bit shifting, start/stop detection and acknowledge.
`default_nettype none
`include "cbc_map.vh"
module cbc_smb_slave (
   // Clock and reset
   input wire core_clk,
   input wire reset,
   // Synchronised bus lines
   input wire scl_s,
   input wire sda_s,
   output reg sda_oe,
   // Own address
   input wire [6:0] dev_addr,
   // Byte events
   output reg start_p,
   output reg stop_p,
   output reg addr_p,
   output reg rd_mode,
   output reg wbyte_p,
   output reg [7:0] wbyte,
   output reg rbyte_req_p,
   input wire [7:0] rbyte
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_WDAT = 3'h2;
   localparam ST_ACK = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_RACK = 3'h5;
   reg scl_q, sda_q;
   reg [2:0] state_q;
   reg [2:0] bit_q;
   reg [7:0] sh_q;
   reg first_q;
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_c = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
   always @(posedge core_clk) begin
      start_p <= 1'b0;
      stop_p <= 1'b0;
      addr_p <= 1'b0;
      wbyte_p <= 1'b0;
      rbyte_req_p <= 1'b0;
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         sda_oe <= 1'b0;
         rd_mode <= 1'b0;
         wbyte <= 8'h00;
         first_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         if (start_c) begin
            // The clock rise that frames a repeated start must not count as a bit.
            start_p <= 1'b1;
            state_q <= ST_ADDR;
            bit_q <= 3'h0;
            first_q <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            stop_p <= 1'b1;
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state_q)
               ST_ADDR, ST_WDAT: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s};
                     bit_q <= bit_q + 3'h1;
                  end
                  if (scl_fall && bit_q == 3'h0 && first_q) begin
                     first_q <= 1'b0;
                     if (state_q == ST_ADDR) begin
                        // Only our own address is acknowledged; others leave the bus.
                        if (sh_q[7:1] == dev_addr) begin
                           addr_p <= 1'b1;
                           rd_mode <= sh_q[0];
                           sda_oe <= 1'b1;
                           state_q <= ST_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        // Every written byte is acknowledged on its own.
                        wbyte <= sh_q;
                        wbyte_p <= 1'b1;
                        sda_oe <= 1'b1;
                        state_q <= ST_ACK;
                     end
                  end else if (scl_rise) begin
                     first_q <= 1'b1;
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 3'h0;
                     first_q <= 1'b0;
                     if (rd_mode) begin
                        state_q <= ST_RDAT;
                        sh_q <= rbyte;
                        sda_oe <= ~rbyte[7];
                        rbyte_req_p <= 1'b1;
                     end else begin
                        sda_oe <= 1'b0;
                        state_q <= ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  if (scl_fall) begin
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == 3'h7) begin
                        sda_oe <= 1'b0;
                        state_q <= ST_RACK;
                     end else begin
                        sda_oe <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b0};
                     end
                  end
               end
               ST_RACK: begin
                  // Host ACK asks for the next byte; NACK ends the read.
                  if (scl_rise) begin
                     state_q <= sda_s ? ST_IDLE : ST_ACK;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // cbc_smb_slave
`default_nettype wire

// file: logic/cbc_top.v
// Clock buffer control: SMBus register bank, pin latching and output gating.
`default_nettype none
`include "cbc_map.vh"
module cbc_top #(
   parameter NUM_OUT = 12,
   parameter [7:0] REV_ID = 8'h11,
   parameter [7:0] DEV_ID = 8'h22
) (
   // Clock and reset
   input wire core_clk,
   input wire reset,
   // SMBus pins
   input wire smb_clk_in,
   input wire smb_data_in,
   output reg smb_data_out,
   output reg smb_data_oe,
   // Board control pins
   input wire power_good_powerdown_n,
   input wire [1:0] pll_mode_pin,
   input wire [1:0] addr_select_pin,
   input wire sel_input_a,
   input wire [NUM_OUT-1:0] out_enable_pin_n,
   // Clock path control
   output reg [NUM_OUT-1:0] diff_clock_out_run,
   output reg feedback_out_run,
   output reg pll_power_on,
   output reg pll_bypass,
   output reg [1:0] pll_mode_applied,
   output reg use_clock_input_a,
   output reg [5:0] skew_steps_early,
   output reg skew_step_p,
   output reg [2:0] skew_step_count
);
   wire [2:0] pin_s;
   wire [1:0] mode_s, addr_s;
   wire [NUM_OUT-1:0] oe_s;
   wire scl_s, sda_s;
   cbc_sync #(.WIDTH(3)) u_sync_ctl (
      .core_clk(core_clk), .reset(reset),
      .async_in({power_good_powerdown_n, sel_input_a, smb_clk_in}),
      .sync_out(pin_s)
   );
   cbc_sync #(.WIDTH(5)) u_sync_tri (
      .core_clk(core_clk), .reset(reset),
      .async_in({pll_mode_pin, addr_select_pin, smb_data_in}),
      .sync_out({mode_s, addr_s, sda_s})
   );
   cbc_sync #(.WIDTH(NUM_OUT)) u_sync_oe (
      .core_clk(core_clk), .reset(reset),
      .async_in(out_enable_pin_n),
      .sync_out(oe_s)
   );
   wire pg_s = pin_s[2];
   wire sel_s = pin_s[1];
   assign scl_s = pin_s[0];

   function [1:0] tri_to_mode;
      input [1:0] tri_lvl;
      begin
         case (tri_lvl)
            `CBC_TRI_LOW: tri_to_mode = `CBC_PLL_LOBW;
            `CBC_TRI_HIGH: tri_to_mode = `CBC_PLL_HIBW;
            default: tri_to_mode = `CBC_PLL_BYPASS;
         endcase
      end
   endfunction
   function [6:0] tri_to_addr;
      input [1:0] tri_lvl;
      begin
         case (tri_lvl)
            `CBC_TRI_LOW: tri_to_addr = `CBC_ADDR_LOW;
            `CBC_TRI_HIGH: tri_to_addr = `CBC_ADDR_HIGH;
            default: tri_to_addr = `CBC_ADDR_MID;
         endcase
      end
   endfunction

   // Strap latch on the first power-good rise after reset.
   reg latched_q, pg_q;
   reg [1:0] mode_latch_q;
   reg [6:0] addr_q;
   always @(posedge core_clk) begin
      if (reset) begin
         latched_q <= 1'b0;
         pg_q <= 1'b0;
         mode_latch_q <= `CBC_PLL_BYPASS;
         addr_q <= `CBC_ADDR_MID;
      end else begin
         pg_q <= pg_s;
         if (pg_s && !pg_q && !latched_q) begin
            latched_q <= 1'b1;
            mode_latch_q <= tri_to_mode(mode_s);
            addr_q <= tri_to_addr(addr_s);
         end
      end
   end

   // Register bank.
   reg [7:0] mode_q, oel_q, oeh_q, count_q;
   reg [2:0] skewa_q, skewb_q;
   reg [7:0] idx_q;
   reg [1:0] phase_q;
   reg [7:0] left_q;
   wire start_p, stop_p, addr_p, rd_mode, wbyte_p, rreq_p, sda_oe;
   wire [7:0] wbyte;
   reg [7:0] rbyte;

   function [7:0] reg_read;
      input [7:0] idx;
      begin
         case (idx)
            // Bits 7:6 latched mode, bit 5 live select pin.
            `CBC_IDX_MODE: reg_read = {mode_latch_q, sel_s, 1'b0, mode_q[3:0]};
            `CBC_IDX_OEL: reg_read = oel_q;
            `CBC_IDX_OEH: reg_read = oeh_q & `CBC_OEH_WMASK;
            `CBC_IDX_REVID: reg_read = REV_ID;
            `CBC_IDX_DEVID: reg_read = DEV_ID;
            `CBC_IDX_COUNT: reg_read = count_q;
            `CBC_IDX_SKEWA: reg_read = {5'h00, skewa_q};
            `CBC_IDX_SKEWB: reg_read = {5'h00, skewb_q};
            default: reg_read = 8'h00;
         endcase
      end
   endfunction

   always @* begin
      // The first read byte is the count, then registers from the index.
      rbyte = (phase_q == 2'h2) ? count_q : reg_read(idx_q);
   end

   always @(posedge core_clk) begin
      skew_step_p <= 1'b0;
      if (reset) begin
         mode_q <= `CBC_MODE_RST;
         oel_q <= `CBC_OEL_RST;
         oeh_q <= `CBC_OEH_RST;
         count_q <= `CBC_COUNT_RST;
         skewa_q <= 3'h0;
         skewb_q <= 3'h0;
         skew_step_count <= 3'h0;
         skew_steps_early <= 6'h00;
         idx_q <= 8'h00;
         phase_q <= 2'h0;
         left_q <= 8'h00;
      end else begin
         if (start_p) begin
            phase_q <= 2'h0;
         end
         if (addr_p) begin
            // A read after the index starts with the count byte.
            phase_q <= rd_mode ? 2'h2 : 2'h0;
            left_q <= count_q;
         end
         if (wbyte_p) begin
            case (phase_q)
               2'h0: begin
                  idx_q <= wbyte;
                  phase_q <= 2'h1;
               end
               2'h1: begin
                  left_q <= wbyte;
                  phase_q <= 2'h3;
               end
               default: begin
                  if (left_q != 8'h00) begin
                     left_q <= left_q - 8'h01;
                     idx_q <= idx_q + 8'h01;
                     case (idx_q)
                        // Only writable bits take the new value.
                        `CBC_IDX_MODE: mode_q <= (mode_q & ~`CBC_MODE_WMASK)
                                                 | (wbyte & `CBC_MODE_WMASK);
                        `CBC_IDX_OEL: oel_q <= wbyte;
                        `CBC_IDX_OEH: oeh_q <= wbyte & `CBC_OEH_WMASK;
                        `CBC_IDX_COUNT: count_q <= wbyte & `CBC_COUNT_WMASK;
                        `CBC_IDX_SKEWA: begin
                           skewa_q <= wbyte[2:0];
                           if (sel_s) begin
                              skew_step_p <= 1'b1;
                              skew_step_count <= wbyte[2:0];
                              skew_steps_early <= skew_steps_early + {3'h0, wbyte[2:0]};
                           end
                        end
                        `CBC_IDX_SKEWB: begin
                           skewb_q <= wbyte[2:0];
                           if (!sel_s) begin
                              skew_step_p <= 1'b1;
                              skew_step_count <= wbyte[2:0];
                              skew_steps_early <= skew_steps_early + {3'h0, wbyte[2:0]};
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            endcase
         end
         if (rreq_p) begin
            if (phase_q == 2'h2) begin
               phase_q <= 2'h3;
            end else begin
               // Index advances per byte; a count of 0 still returns data.
               idx_q <= idx_q + 8'h01;
            end
         end
      end
   end

   cbc_smb_slave u_smb (
      .core_clk(core_clk), .reset(reset),
      .scl_s(scl_s), .sda_s(sda_s), .sda_oe(sda_oe),
      .dev_addr(addr_q),
      .start_p(start_p), .stop_p(stop_p), .addr_p(addr_p), .rd_mode(rd_mode),
      .wbyte_p(wbyte_p), .wbyte(wbyte),
      .rbyte_req_p(rreq_p), .rbyte(rbyte)
   );

   // Output control.
   wire sw_en = mode_q[`CBC_BIT_SWEN];
   wire [1:0] mode_eff = sw_en ? mode_q[2:1] : mode_latch_q;
   wire [11:0] en_bits = {oeh_q[3:0], oel_q};
   always @(posedge core_clk) begin
      if (reset) begin
         smb_data_out <= 1'b0;
         smb_data_oe <= 1'b0;
         diff_clock_out_run <= {NUM_OUT{1'b0}};
         feedback_out_run <= 1'b0;
         pll_power_on <= 1'b0;
         pll_bypass <= 1'b0;
         pll_mode_applied <= `CBC_PLL_BYPASS;
         use_clock_input_a <= 1'b0;
      end else begin
         smb_data_oe <= sda_oe;
         pll_mode_applied <= mode_eff;
         pll_bypass <= (mode_eff == `CBC_PLL_BYPASS);
         use_clock_input_a <= sel_s;
         if (!pg_s) begin
            diff_clock_out_run <= {NUM_OUT{1'b0}};
            feedback_out_run <= 1'b0;
            pll_power_on <= 1'b0;
         end else begin
            // Register bit 0 forces low/low; 1 defers to the active-low pin.
            diff_clock_out_run <= en_bits[NUM_OUT-1:0] & ~oe_s;
            feedback_out_run <= 1'b1;
            pll_power_on <= (mode_eff != `CBC_PLL_BYPASS);
         end
      end
   end
endmodule // cbc_top
`default_nettype wire

// file: tb/cbc_sva.sv
// Concurrent checks on the ports of the clock buffer control block.
`default_nettype none
module cbc_sva #(
   parameter NUM_OUT = 12
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Pins
   input wire logic smb_clk_in,
   input wire logic smb_data_oe,
   input wire logic power_good_powerdown_n,
   input wire logic sel_input_a,
   input wire logic [NUM_OUT-1:0] out_enable_pin_n,
   // Clock path control
   input wire logic [NUM_OUT-1:0] diff_clock_out_run,
   input wire logic feedback_out_run,
   input wire logic pll_power_on,
   input wire logic pll_bypass,
   input wire logic [1:0] pll_mode_applied,
   input wire logic use_clock_input_a,
   input wire logic [5:0] skew_steps_early,
   input wire logic skew_step_p,
   input wire logic [2:0] skew_step_count
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   property p_pd_off;
      !power_good_powerdown_n [*5] |-> diff_clock_out_run == '0 && !feedback_out_run
         && !pll_power_on;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("clock path active in power down");
   property p_run_fb;
      |diff_clock_out_run |-> feedback_out_run;
   endproperty
   a_run_fb: assert property (p_run_fb) else $error("output runs without feedback");
   property p_pll_on;
      power_good_powerdown_n [*8] |-> feedback_out_run && pll_power_on == !pll_bypass;
   endproperty
   a_pll_on: assert property (p_pll_on) else $error("feedback or PLL state wrong");
   property p_pin_gate;
      $stable(out_enable_pin_n) [*5] |-> (diff_clock_out_run & out_enable_pin_n) == '0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled output runs");
   property p_byp_off;
      pll_bypass |-> !pll_power_on && pll_mode_applied == 2'h1;
   endproperty
   a_byp_off: assert property (p_byp_off) else $error("PLL powered in bypass");
   property p_code;
      pll_mode_applied != 2'h2;
   endproperty
   a_code: assert property (p_code) else $error("undefined PLL mode code");
   property p_skew;
      $changed(skew_steps_early) |->
         skew_steps_early == $past(skew_steps_early) + 6'(skew_step_count);
   endproperty
   a_skew: assert property (p_skew) else $error("skew did not accumulate");
   property p_oe_low;
      $changed(smb_data_oe) |-> !smb_clk_in;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("data line moved while clock high");
   property p_sel;
      $stable(sel_input_a) [*6] |-> use_clock_input_a == sel_input_a;
   endproperty
   a_sel: assert property (p_sel) else $error("input select does not follow pin");
   c_skew: cover property (skew_step_p);
   c_ack: cover property ($rose(smb_data_oe));
   c_byp: cover property (pll_bypass && power_good_powerdown_n);
endmodule // cbc_sva
bind cbc_top cbc_sva #(.NUM_OUT(NUM_OUT)) cbc_sva_i (.core_clk(core_clk), .reset(reset),
   .smb_clk_in(smb_clk_in), .smb_data_oe(smb_data_oe),
   .power_good_powerdown_n(power_good_powerdown_n), .sel_input_a(sel_input_a),
   .out_enable_pin_n(out_enable_pin_n), .diff_clock_out_run(diff_clock_out_run),
   .feedback_out_run(feedback_out_run), .pll_power_on(pll_power_on), .pll_bypass(pll_bypass),
   .pll_mode_applied(pll_mode_applied), .use_clock_input_a(use_clock_input_a),
   .skew_steps_early(skew_steps_early), .skew_step_p(skew_step_p),
   .skew_step_count(skew_step_count));
`default_nettype wire

// file: tb/cbc_host.sv
// Behavioural SMBus host running indexed block writes and block reads.
`default_nettype none
module cbc_host (
   // Clock
   input wire logic core_clk,
   // Bus lines
   output logic scl,
   output logic host_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   int nacks;
   logic [7:0] rdat [0:10];
   initial begin
      scl = 1'b1;
      host_low = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // A high bit releases the line; the level seen mid high phase is returned.
   task automatic bit_io(input logic b, output logic r);
      wait_n(2);
      host_low = !b;
      wait_n(3);
      scl = 1'b1;
      wait_n(2);
      r = sda;
      wait_n(3);
      scl = 1'b0;
   endtask
   task automatic start;
      wait_n(5);
      host_low = 1'b0;
      wait_n(5);
      scl = 1'b1;
      wait_n(3);
      host_low = 1'b1;
      wait_n(3);
      scl = 1'b0;
   endtask
   task automatic stop;
      wait_n(5);
      host_low = 1'b1;
      wait_n(5);
      scl = 1'b1;
      wait_n(3);
      host_low = 1'b0;
      wait_n(3);
   endtask
   task automatic xfer(input logic [7:0] d, input logic dev, input logic last,
      output logic [7:0] r);
      logic k;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(dev | last, k);
      if (dev && k) nacks++;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [15:0] d,
      input int len);
      logic [7:0] r;
      nacks = 0;
      start();
      xfer({a, 1'b0}, 1'b1, 1'b0, r);
      xfer(n, 1'b1, 1'b0, r);
      xfer(8'(len), 1'b1, 1'b0, r);
      for (int j = len - 1; j >= 0; j--) xfer(d[j * 8 +: 8], 1'b1, 1'b0, r);
      stop();
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] n, input int cnt);
      logic [7:0] r;
      nacks = 0;
      start();
      xfer({a, 1'b0}, 1'b1, 1'b0, r);
      xfer(n, 1'b1, 1'b0, r);
      start();
      xfer({a, 1'b1}, 1'b1, 1'b0, r);
      for (int j = 0; j <= cnt; j++) xfer(8'hFF, 1'b0, j == cnt, rdat[j]);
      stop();
   endtask
endmodule // cbc_host
`default_nettype wire

// file: tb/smbus_clock_buffer_control_tb_top.sv
// Self-checking bench for the clock buffer control block.
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module smbus_clock_buffer_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] REV_ID = 8'h5A; // Arbitrary value.
   localparam logic [7:0] DEV_ID = 8'hA5; // Arbitrary value.
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic pg = 1'b0;
   logic sel_a = 1'b1;
   logic [1:0] mode_pin = 2'h0;
   logic [1:0] addr_pin = 2'h0;
   logic [11:0] oe_n = 12'h000;
   logic scl, host_low, oe, dout, fb, pll_on, byp, use_a, stp;
   logic [11:0] run;
   logic [1:0] mode;
   logic [5:0] steps;
   logic [2:0] scnt;
   wire sda;
   int error_cnt = 0;
   int samples_checked = 0;
   assign sda = !(host_low || (oe && !dout));
   always #4 core_clk = ~core_clk;
   cbc_top #(.NUM_OUT(12), .REV_ID(REV_ID), .DEV_ID(DEV_ID)) cbc_top_i (.core_clk(core_clk),
      .reset(reset), .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out(dout),
      .smb_data_oe(oe), .power_good_powerdown_n(pg), .pll_mode_pin(mode_pin),
      .addr_select_pin(addr_pin), .sel_input_a(sel_a), .out_enable_pin_n(oe_n),
      .diff_clock_out_run(run), .feedback_out_run(fb), .pll_power_on(pll_on),
      .pll_bypass(byp), .pll_mode_applied(mode), .use_clock_input_a(use_a),
      .skew_steps_early(steps), .skew_step_p(stp), .skew_step_count(scnt));
   cbc_host cbc_host_i (.core_clk(core_clk), .scl(scl), .host_low(host_low), .sda(sda));
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic boot(input logic [1:0] mp, input logic [1:0] ap);
      reset = 1'b1;
      pg = 1'b0;
      wait_n(5);
      reset = 1'b0;
      mode_pin = mp;
      addr_pin = ap;
      wait_n(8);
      `CHK({run, fb, pll_on}, 14'h0000)
      pg = 1'b1;
      wait_n(10);
   endtask
   task automatic t_straps;
      logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
      logic [6:0] adr [3] = '{7'h6D, 7'h6F, 7'h6C};
      for (int i = 0; i < 3; i++) begin
         sel_a = i[0];
         boot(2'(i), 2'((i + 1) % 3));
         mode_pin = ~mode_pin;
         wait_n(5);
         cbc_host_i.rd(adr[i], 8'h00, 1);
         `CHK(cbc_host_i.nacks, 0)
         `CHK(cbc_host_i.rdat[1], {code[i], sel_a, 5'h07})
         `CHK({mode, byp, pll_on, use_a}, {code[i], code[i] == 2'h1, code[i] != 2'h1, sel_a})
         cbc_host_i.rd(adr[(i + 1) % 3], 8'h00, 0);
         `CHK(cbc_host_i.nacks, 3)
      end
   endtask
   task automatic t_defaults;
      logic [7:0] e [9];
      e = '{{2'h3, sel_a, 5'h07}, 8'hFF, 8'h0F, 8'h00, 8'h00, REV_ID, DEV_ID, 8'h08, 8'h00};
      cbc_host_i.rd(7'h6C, 8'h00, 9);
      `CHK(cbc_host_i.rdat[0], 8'h08)
      for (int i = 0; i < 9; i++) `CHK(cbc_host_i.rdat[i + 1], e[i])
      `CHK(run, 12'hFFF)
   endtask
   task automatic t_write;
      oe_n = 12'h001;
      cbc_host_i.wr(7'h6C, 8'h01, 16'hA5F3, 2);
      `CHK(cbc_host_i.nacks, 0)
      `CHK(run, 12'h3A4)
      cbc_host_i.rd(7'h6C, 8'h01, 2);
      `CHK({cbc_host_i.rdat[1], cbc_host_i.rdat[2]}, 16'hA503)
      cbc_host_i.wr(7'h6C, 8'h01, 16'hFFFF, 2);
      oe_n = 12'h000;
   endtask
   task automatic t_mode;
      cbc_host_i.wr(7'h6C, 8'h00, 16'h0008, 1);
      wait_n(5);
      `CHK({mode, byp, pll_on}, 4'h1)
      cbc_host_i.wr(7'h6C, 8'h00, 16'h00FB, 1);
      wait_n(5);
      `CHK({mode, byp, pll_on}, 4'h6)
      cbc_host_i.rd(7'h6C, 8'h00, 1);
      `CHK(cbc_host_i.rdat[1], {2'h3, sel_a, 5'h0B})
      boot(2'h2, 2'h0);
   endtask
   task automatic t_skew;
      logic [1:0] sx [5] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
      logic [2:0] v [5] = '{3'h1, 3'h7, 3'h7, 3'h6, 3'h0};
      logic [5:0] ex [5] = '{6'h01, 6'h08, 6'h08, 6'h0E, 6'h0E};
      for (int i = 0; i < 5; i++) begin
         sel_a = sx[i][1];
         wait_n(5);
         cbc_host_i.wr(7'h6C, {7'h04, sx[i][0]}, {13'h0000, v[i]}, 1);
         `CHK(steps, ex[i])
      end
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      t_straps();
      t_defaults();
      t_write();
      t_mode();
      t_skew();
      conclude();
   end
   initial begin
      #500000;
      error_cnt++;
      conclude();
   end
endmodule // smbus_clock_buffer_control_tb_top
`default_nettype wire
